//--- dv/rxcim_host.sv
module rxcim_host (
   // clock
   input wire logic clock,
   // bus request
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [11:0] adr,
   output logic [3:0] sel,
   output logic [31:0] dat,
   // bus answer
   input wire logic [31:0] rdat,
   input wire logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 12'h000;
      sel = 4'h0;
      dat = 32'h00000000;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= {24'h000000, d};
      do @(posedge clock); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // released lines must not keep the last value
      adr <= ~a;
      dat <= ~{24'h000000, d};
   endtask
endmodule

//--- dv/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ERRS [4] = '{30, 31, -35, -36};
   logic clock, rst, cyc, stb, we, ack, rate_accept, irq;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] dat, rdat, q;
   logic [15:0] rx_event;
   logic [7:0] strength_raw, b;
   logic [9:0] mi, si;
   logic signed [10:0] strength_corr;
   logic signed [8:0] rate_error;
   int mismatches = 0;
   int check_count = 0;
   rxcim_host u_host (.clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
      .dat(dat), .rdat(rdat), .ack(ack));
   rxcim_regs u_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .rx_event(rx_event), .strength_raw(strength_raw), .strength_corr(strength_corr),
      .rate_error(rate_error), .rate_accept(rate_accept), .irq(irq));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      u_host.xfer(1'b1, {i, 2'b00}, d, q);
   endtask
   task automatic rdc(input logic [9:0] i, input logic [7:0] e);
      u_host.xfer(1'b0, {i, 2'b00}, 8'h00, q);
      chk(q, {24'h000000, e});
   endtask
   task automatic end_sim;
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      end_sim;
   end
   initial begin
      rst = 1'b1;
      rx_event = 16'h0000;
      strength_raw = 8'h00;
      rate_error = 9'h000;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rdc(rxcim_pkg::IDX_OFFS, 8'h80);
      rdc(rxcim_pkg::IDX_SLOPE, 8'h80);
      rdc(rxcim_pkg::IDX_POS, 8'h1E);
      rdc(rxcim_pkg::IDX_NEG, 8'h23);
      rdc(rxcim_pkg::IDX_MASK_AB, 8'h00);
      rdc(rxcim_pkg::IDX_MASK_CD, 8'h00);
      wr(10'h3FF, 8'h5A);
      rdc(10'h3FF, 8'h00);
      wr(rxcim_pkg::IDX_MASK_AB, 8'hA5);
      rdc(rxcim_pkg::IDX_MASK_AB, 8'hA5);
      wr(rxcim_pkg::IDX_MASK_CD, 8'h5A);
      rdc(rxcim_pkg::IDX_MASK_CD, 8'h5A);
      // 200*255/128 + 254
      strength_raw <= 8'd200;
      wr(rxcim_pkg::IDX_OFFS, 8'hFF);
      wr(rxcim_pkg::IDX_SLOPE, 8'hFF);
      repeat (3) @(posedge clock);
      chk({{21{strength_corr[10]}}, strength_corr}, 32'd652);
      // 200*64/128 - 256
      wr(rxcim_pkg::IDX_OFFS, 8'h00);
      wr(rxcim_pkg::IDX_SLOPE, 8'h40);
      repeat (3) @(posedge clock);
      chk({{21{strength_corr[10]}}, strength_corr}, 32'hFFFFFF64);
      // 200*64/128 with zero offset
      wr(rxcim_pkg::IDX_OFFS, 8'h80);
      repeat (3) @(posedge clock);
      chk({{21{strength_corr[10]}}, strength_corr}, 32'd100);
      rate_error <= 9'sd100;
      repeat (3) @(posedge clock);
      chk({31'h0, rate_accept}, 32'h1);
      wr(rxcim_pkg::IDX_LOOP_CFG, 8'h01);
      for (int k = 0; k < 4; k++) begin
         rate_error <= 9'(ERRS[k]);
         repeat (3) @(posedge clock);
         chk({31'h0, rate_accept}, {31'h0, 1'(k % 2 == 0)});
      end
      for (int i = 0; i < 32; i++) begin
         mi = (i % 16 < 8) ? rxcim_pkg::IDX_MASK_AB : rxcim_pkg::IDX_MASK_CD;
         si = (i % 16 < 8) ? rxcim_pkg::IDX_STAT_AB : rxcim_pkg::IDX_STAT_CD;
         b = 8'h01 << (i % 8);
         wr(mi, (i < 16) ? 8'h00 : b);
         rx_event <= 16'h0001 << (i % 16);
         @(posedge clock);
         rx_event <= 16'h0000;
         repeat (3) @(posedge clock);
         chk({31'h0, irq}, {31'h0, 1'(i < 16)});
         rdc(si, b);
         wr(mi, 8'h00);
         repeat (2) @(posedge clock);
         chk({31'h0, irq}, 32'h1);
         wr(si, b);
         repeat (2) @(posedge clock);
         chk({31'h0, irq}, 32'h0);
      end
      end_sim;
   end
endmodule

//--- src/rxcim_pkg.sv
package rxcim_pkg;
   localparam int CODE_W = 8;
   localparam int EVT_N = 16;
   localparam int IDX_W = 10;
   localparam int WB_ADR_W = 12;
   localparam int WB_DAT_W = 32;
   localparam int IDX_LSB = 2;
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_OFFS = 10'h090;
   localparam logic [IDX_W-1:0] IDX_SLOPE = 10'h091;
   localparam logic [IDX_W-1:0] IDX_POS = 10'h092;
   localparam logic [IDX_W-1:0] IDX_NEG = 10'h093;
   localparam logic [IDX_W-1:0] IDX_MASK_AB = 10'h094;
   localparam logic [IDX_W-1:0] IDX_MASK_CD = 10'h095;
   localparam logic [IDX_W-1:0] IDX_LOOP_CFG = 10'h0A0;
   localparam logic [IDX_W-1:0] IDX_STAT_AB = 10'h0A1;
   localparam logic [IDX_W-1:0] IDX_STAT_CD = 10'h0A2;
   // reset values
   localparam logic [CODE_W-1:0] RST_OFFS = 8'h80;
   localparam logic [CODE_W-1:0] RST_SLOPE = 8'h80;
   localparam logic [CODE_W-1:0] RST_POS = 8'h1E;
   localparam logic [CODE_W-1:0] RST_NEG = 8'h23;
   localparam logic [CODE_W-1:0] RST_MASK = 8'h00;
   localparam logic [CODE_W-1:0] RST_LOOP_CFG = 8'h00;
   // field positions
   localparam int RATE_LIMIT_EN_BIT = 0;
   localparam int SLOPE_SHIFT = 7;
   localparam logic [9:0] OFFS_BIAS = 10'h100;
   localparam int CFG_LO = 0;
   localparam int CFG_HI = 8;
   // event order inside a configuration nibble
   localparam int EVT_WAKEUP = 0;
   localparam int EVT_FRAME_SYNC = 1;
   localparam int EVT_ID_FOUND = 2;
   localparam int EVT_END_MSG = 3;
endpackage

//--- src/rxcim_regs.sv
module rxcim_regs #(
   parameter int RAW_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [rxcim_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [rxcim_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic [rxcim_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   // receive events, one pulse each, index cfg*4 + event
   input wire logic [rxcim_pkg::EVT_N-1:0] rx_event,
   // strength reading
   input wire logic [RAW_W-1:0] strength_raw,
   output logic signed [RAW_W+2:0] strength_corr,
   // data rate check
   input wire logic signed [8:0] rate_error,
   output logic rate_accept,
   // interrupt
   output logic irq
);
   logic [rxcim_pkg::CODE_W-1:0] offs_q, offs_d;
   logic [rxcim_pkg::CODE_W-1:0] slope_q, slope_d;
   logic [rxcim_pkg::CODE_W-1:0] pos_q, pos_d;
   logic [rxcim_pkg::CODE_W-1:0] neg_q, neg_d;
   logic [rxcim_pkg::CODE_W-1:0] loop_cfg_q, loop_cfg_d;
   logic [rxcim_pkg::EVT_N-1:0] mask_q, mask_d;
   logic [rxcim_pkg::EVT_N-1:0] status_q, status_d;
   logic [rxcim_pkg::EVT_N-1:0] status_clr;
   logic [rxcim_pkg::WB_DAT_W-1:0] dat_q, dat_d;
   logic ack_q, ack_d;
   logic irq_q, irq_d;
   logic accept_q, accept_d;
   logic [rxcim_pkg::IDX_W-1:0] idx;
   logic wr_en;
   logic [rxcim_pkg::CODE_W-1:0] wr_byte;
   logic [rxcim_pkg::CODE_W-1:0] rd_byte;
   logic rate_limit_enable;
   logic signed [9:0] err_ext;
   logic [9:0] err_mag;

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign irq = irq_q;
   assign rate_accept = accept_q;
   assign rate_limit_enable = loop_cfg_q[rxcim_pkg::RATE_LIMIT_EN_BIT];

   // bus slave: ack one cycle after the request, write commits at the ack edge
   always_comb begin
      idx = wb_adr_i[rxcim_pkg::IDX_LSB +: rxcim_pkg::IDX_W];
      wr_byte = wb_dat_i[rxcim_pkg::CODE_W-1:0];
      wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      case (idx)
         rxcim_pkg::IDX_OFFS: rd_byte = offs_q;
         rxcim_pkg::IDX_SLOPE: rd_byte = slope_q;
         rxcim_pkg::IDX_POS: rd_byte = pos_q;
         rxcim_pkg::IDX_NEG: rd_byte = neg_q;
         rxcim_pkg::IDX_MASK_AB: rd_byte = mask_q[rxcim_pkg::CFG_LO +: 8];
         rxcim_pkg::IDX_MASK_CD: rd_byte = mask_q[rxcim_pkg::CFG_HI +: 8];
         rxcim_pkg::IDX_LOOP_CFG: rd_byte = loop_cfg_q;
         rxcim_pkg::IDX_STAT_AB: rd_byte = status_q[rxcim_pkg::CFG_LO +: 8];
         rxcim_pkg::IDX_STAT_CD: rd_byte = status_q[rxcim_pkg::CFG_HI +: 8];
         default: rd_byte = '0;
      endcase
      dat_d = (ack_d && !wb_we_i) ? {24'h000000, rd_byte} : '0;
   end

   // software writable codes and masks
   always_comb begin
      offs_d = offs_q;
      slope_d = slope_q;
      pos_d = pos_q;
      neg_d = neg_q;
      loop_cfg_d = loop_cfg_q;
      mask_d = mask_q;
      status_clr = '0;
      if (wr_en) begin
         case (idx)
            rxcim_pkg::IDX_OFFS: offs_d = wr_byte;
            rxcim_pkg::IDX_SLOPE: slope_d = wr_byte;
            rxcim_pkg::IDX_POS: pos_d = wr_byte;
            rxcim_pkg::IDX_NEG: neg_d = wr_byte;
            rxcim_pkg::IDX_LOOP_CFG: loop_cfg_d = wr_byte;
            rxcim_pkg::IDX_MASK_AB: mask_d[rxcim_pkg::CFG_LO +: 8] = wr_byte;
            rxcim_pkg::IDX_MASK_CD: mask_d[rxcim_pkg::CFG_HI +: 8] = wr_byte;
            rxcim_pkg::IDX_STAT_AB: status_clr[rxcim_pkg::CFG_LO +: 8] = wr_byte;
            rxcim_pkg::IDX_STAT_CD: status_clr[rxcim_pkg::CFG_HI +: 8] = wr_byte;
            default: offs_d = offs_q;
         endcase
      end
   end

   // sticky event flags, one per event and configuration; a new event beats a clear
   for (genvar i = 0; i < rxcim_pkg::EVT_N; i++) begin : g_evt
      always_comb begin
         status_d[i] = rx_event[i] || (status_q[i] && !status_clr[i]);
      end
   end

   // interrupt and rate check
   always_comb begin
      irq_d = |(status_q & ~mask_q);
      err_ext = {rate_error[8], rate_error};
      err_mag = err_ext[9] ? 10'(-err_ext) : 10'(err_ext);
      if (!rate_limit_enable) begin
         accept_d = 1'b1;
      end else if (!err_ext[9]) begin
         accept_d = err_mag <= {2'b00, pos_q};
      end else begin
         accept_d = err_mag <= {2'b00, neg_q};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         offs_q <= rxcim_pkg::RST_OFFS;
         slope_q <= rxcim_pkg::RST_SLOPE;
         pos_q <= rxcim_pkg::RST_POS;
         neg_q <= rxcim_pkg::RST_NEG;
         loop_cfg_q <= rxcim_pkg::RST_LOOP_CFG;
         mask_q <= {rxcim_pkg::RST_MASK, rxcim_pkg::RST_MASK};
         status_q <= '0;
         dat_q <= '0;
         ack_q <= 1'b0;
         irq_q <= 1'b0;
         accept_q <= 1'b1;
      end else begin
         offs_q <= offs_d;
         slope_q <= slope_d;
         pos_q <= pos_d;
         neg_q <= neg_d;
         loop_cfg_q <= loop_cfg_d;
         mask_q <= mask_d;
         status_q <= status_d;
         dat_q <= dat_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
         accept_q <= accept_d;
      end
   end

   rxcim_strength_corr #(
      .RAW_W(RAW_W)
   ) u_corr (
      .clock(clock),
      .rst(rst),
      .strength_offset_code(offs_q),
      .strength_slope_code(slope_q),
      .strength_raw(strength_raw),
      .strength_corr(strength_corr)
   );

   sequence wr_mask_ab_s;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && idx == rxcim_pkg::IDX_MASK_AB;
   endsequence

   sequence wr_mask_cd_s;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && idx == rxcim_pkg::IDX_MASK_CD;
   endsequence

   sequence quiet_s;
      ((status_q & ~mask_q) == '0) [*2];
   endsequence

   mask_ab_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_mask_ab_s |=> mask_q[7:0] == $past(wb_dat_i[7:0]) && mask_q[15:8] == $past(mask_q[15:8]))
      else $error("first mask register not loaded from bus");

   mask_cd_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_mask_cd_s |=> mask_q[15:8] == $past(wb_dat_i[7:0]) && mask_q[7:0] == $past(mask_q[7:0]))
      else $error("second mask register not loaded from bus");

   irq_gate_a: assert property (@(posedge clock) disable iff (rst)
      ##1 irq == |($past(status_q) & ~$past(mask_q)))
      else $error("interrupt does not follow unmasked flags");

   event_latch_a: assert property (@(posedge clock) disable iff (rst)
      (|rx_event) |=> (status_q & $past(rx_event)) == $past(rx_event))
      else $error("event not latched in its own flag");

   mask_reset_a: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> mask_q == '0 && !irq)
      else $error("mask not clear after reset");

   masked_quiet_a: assert property (@(posedge clock) disable iff (rst)
      quiet_s |=> !irq)
      else $error("interrupt raised by masked event only");

   rate_pos_a: assert property (@(posedge clock) disable iff (rst)
      rate_limit_enable && !rate_error[8] && {1'b0, rate_error} > {2'b00, pos_q}
      |=> !rate_accept)
      else $error("rate above positive threshold accepted");

   rate_neg_a: assert property (@(posedge clock) disable iff (rst)
      rate_limit_enable && rate_error[8] && 10'(-{rate_error[8], rate_error}) <= {2'b00, neg_q}
      |=> rate_accept)
      else $error("rate within negative threshold refused");

   rate_off_a: assert property (@(posedge clock) disable iff (rst)
      !rate_limit_enable |=> rate_accept)
      else $error("rate check active while disabled");

   // bus handshake and read path
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence rd_req_s;
      wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   endsequence

   sequence wr_commit_s;
      wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   endsequence

   ack_after_req_a: assert property (@(posedge clock) disable iff (rst)
      req_s |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");

   ack_pulse_a: assert property (@(posedge clock) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held for more than one cycle");

   ack_no_req_a: assert property (@(posedge clock) disable iff (rst)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("acknowledge given without a request");

   rd_idle_zero_a: assert property (@(posedge clock) disable iff (rst)
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("read data not zero outside acknowledge");

   rd_offs_a: assert property (@(posedge clock) disable iff (rst)
      rd_req_s ##0 (idx == rxcim_pkg::IDX_OFFS) |=> wb_dat_o == {24'h000000, $past(offs_q)})
      else $error("offset code read back wrong");

   rd_mask_ab_a: assert property (@(posedge clock) disable iff (rst)
      rd_req_s ##0 (idx == rxcim_pkg::IDX_MASK_AB) |=>
      wb_dat_o == {24'h000000, $past(mask_q[7:0])})
      else $error("first mask register read back wrong");

   rd_mask_cd_a: assert property (@(posedge clock) disable iff (rst)
      rd_req_s ##0 (idx == rxcim_pkg::IDX_MASK_CD) |=>
      wb_dat_o == {24'h000000, $past(mask_q[15:8])})
      else $error("second mask register read back wrong");

   rd_stat_ab_a: assert property (@(posedge clock) disable iff (rst)
      rd_req_s ##0 (idx == rxcim_pkg::IDX_STAT_AB) |=>
      wb_dat_o == {24'h000000, $past(status_q[7:0])})
      else $error("first status register read back wrong");

   rd_stat_cd_a: assert property (@(posedge clock) disable iff (rst)
      rd_req_s ##0 (idx == rxcim_pkg::IDX_STAT_CD) |=>
      wb_dat_o == {24'h000000, $past(status_q[15:8])})
      else $error("second status register read back wrong");

   // register writes land at the acknowledge edge
   offs_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_OFFS) |=> offs_q == $past(wb_dat_i[7:0]))
      else $error("offset code not loaded from bus");

   slope_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_SLOPE) |=> slope_q == $past(wb_dat_i[7:0]))
      else $error("slope code not loaded from bus");

   pos_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_POS) |=> pos_q == $past(wb_dat_i[7:0]))
      else $error("positive threshold not loaded from bus");

   neg_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_NEG) |=> neg_q == $past(wb_dat_i[7:0]))
      else $error("negative threshold not loaded from bus");

   loop_cfg_write_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_LOOP_CFG) |=> loop_cfg_q == $past(wb_dat_i[7:0]))
      else $error("loop configuration not loaded from bus");

   codes_reset_a: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> offs_q == rxcim_pkg::RST_OFFS && slope_q == rxcim_pkg::RST_SLOPE
      && pos_q == rxcim_pkg::RST_POS && neg_q == rxcim_pkg::RST_NEG
      && loop_cfg_q == rxcim_pkg::RST_LOOP_CFG && status_q == '0)
      else $error("codes not at reset values after reset");

   status_ab_clear_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_STAT_AB) |=> status_q[7:0] ==
      (($past(status_q[7:0]) & ~$past(wb_dat_i[7:0])) | $past(rx_event[7:0])))
      else $error("first status register not cleared by writing ones");

   status_cd_clear_a: assert property (@(posedge clock) disable iff (rst)
      wr_commit_s ##0 (idx == rxcim_pkg::IDX_STAT_CD) |=> status_q[15:8] ==
      (($past(status_q[15:8]) & ~$past(wb_dat_i[7:0])) | $past(rx_event[15:8])))
      else $error("second status register not cleared by writing ones");

   status_hold_a: assert property (@(posedge clock) disable iff (rst)
      !wr_en && !(|rx_event) |=> $stable(status_q))
      else $error("event flag changed without event or clear");

   rate_pos_accept_a: assert property (@(posedge clock) disable iff (rst)
      rate_limit_enable && !rate_error[8] && {1'b0, rate_error} <= {2'b00, pos_q}
      |=> rate_accept)
      else $error("rate within positive threshold refused");

   rate_neg_refuse_a: assert property (@(posedge clock) disable iff (rst)
      rate_limit_enable && rate_error[8] && 10'(-{rate_error[8], rate_error}) > {2'b00, neg_q}
      |=> !rate_accept)
      else $error("rate below negative threshold accepted");

   for (genvar j = 0; j < rxcim_pkg::EVT_N; j++) begin : g_irq_chk
      unmasked_raise_a: assert property (@(posedge clock) disable iff (rst)
         status_q[j] && !mask_q[j] |=> irq)
         else $error("unmasked event flag did not raise the interrupt");
   end
endmodule

//--- src/rxcim_strength_corr.sv
module rxcim_strength_corr #(
   parameter int RAW_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // codes and raw reading
   input wire logic [rxcim_pkg::CODE_W-1:0] strength_offset_code,
   input wire logic [rxcim_pkg::CODE_W-1:0] strength_slope_code,
   input wire logic [RAW_W-1:0] strength_raw,
   // corrected reading
   output logic signed [RAW_W+2:0] strength_corr
);
   localparam int PROD_W = RAW_W + rxcim_pkg::CODE_W;
   logic [PROD_W-1:0] prod;
   logic [RAW_W:0] scaled;
   logic signed [9:0] offs;
   logic signed [RAW_W+2:0] corr_d;

   always_comb begin
      prod = PROD_W'(strength_raw) * PROD_W'(strength_slope_code);
      scaled = prod[rxcim_pkg::SLOPE_SHIFT +: RAW_W+1];
      offs = $signed({1'b0, strength_offset_code, 1'b0} - rxcim_pkg::OFFS_BIAS);
      corr_d = $signed({2'b00, scaled}) + (RAW_W+3)'(offs);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         strength_corr <= '0;
      end else begin
         strength_corr <= corr_d;
      end
   end

   offset_map_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $past(strength_slope_code) == rxcim_pkg::RST_SLOPE |->
      strength_corr == $signed({3'b000, $past(strength_raw)})
      + $signed({2'b00, $past(strength_offset_code), 1'b0})
      - $signed({1'b0, rxcim_pkg::OFFS_BIAS}))
      else $error("offset code not applied linearly");

   slope_map_a: assert property (@(posedge clock) disable iff (rst)
      !$past(rst) && $past(strength_offset_code) == rxcim_pkg::RST_OFFS |->
      strength_corr == $signed({2'b00, 9'((PROD_W'($past(strength_raw))
      * PROD_W'($past(strength_slope_code))) >> rxcim_pkg::SLOPE_SHIFT)}))
      else $error("slope code not applied as code over 128");
endmodule
